// File: logic/lpm_exit_pkg.sv
`default_nettype none
package lpm_exit_pkg;
    typedef enum logic [2:0]
    {
        MODE_ACTIVE = 3'b000,
        MODE_SLEEP = 3'b001,
        MODE_STANDBY = 3'b010,
        MODE_WATCH = 3'b011,
        MODE_SUBSLEEP = 3'b100,
        MODE_SUBACTIVE = 3'b101,
        MODE_MEDIUM = 3'b110
    } mode_e;

    typedef struct packed {
        logic standbySelect;
        logic lowSpeedOn;
        logic timerClockSelectHi;
    } system_control_1_s;

    typedef struct packed {
        logic mediumSpeedOn;
        logic directTransferOn;
    } system_control_2_s;

    localparam logic [31:0] ADDR_CONTROL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam int CTRL_STANDBY_BIT = 0;
    localparam int CTRL_LOW_SPEED_BIT = 1;
    localparam int CTRL_TIMER_SEL_BIT = 2;
    localparam int CTRL_MEDIUM_BIT = 3;
    localparam int CTRL_DIRECT_BIT = 4;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_OSC_BIT = 4;
    localparam int STAT_CPURST_BIT = 5;
    localparam int STAT_EXC_BIT = 6;
    localparam logic [4:0] CONTROL_RESET = 5'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lpm_exit_pkg
`default_nettype wire

// File: logic/low_power_mode_exit_reset.sv
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_exit_reset
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // reset pin and sources
    input wire logic externalResetPin_n,
    input wire logic internalResetSrc,
    // processor side
    input wire logic sleepRequest,
    input wire logic interruptRequest,
    input wire logic interruptEnabled,
    input wire logic interruptMask,
    input wire logic oscStable,
    output logic oscEnable,
    output logic cpuReset,
    output logic resetException,
    output logic memoryRetained,
    output logic regsRetained,
    output lpm_exit_pkg::mode_e mode,
    // axi4-lite slave
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import lpm_exit_pkg::*;

    logic pinMeta_q, pinSync_q, pinPrev_q;
    logic [4:0] ctrl_q, ctrl_d;
    mode_e mode_q, mode_d;
    logic osc_q, osc_d;
    logic exc_q, exc_d;
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d;
    logic [31:0] awAddr_q, awAddr_d, wData_q, wData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic pinLow, resetSrc, lowPower, wakeOk;
    system_control_1_s sc1;
    system_control_2_s sc2;

    // pin synchroniser
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
            pinPrev_q <= 1'b0;
        end
        else
        begin
            pinMeta_q <= externalResetPin_n;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    assign pinLow = !pinSync_q;
    assign resetSrc = pinLow || internalResetSrc;
    assign lowPower = (mode_q == MODE_STANDBY) || (mode_q == MODE_WATCH)
        || (mode_q == MODE_SUBSLEEP) || (mode_q == MODE_SUBACTIVE);
    assign wakeOk = interruptRequest && interruptEnabled
        && !interruptMask;
    assign sc1 = '{ctrl_q[CTRL_STANDBY_BIT], ctrl_q[CTRL_LOW_SPEED_BIT],
        ctrl_q[CTRL_TIMER_SEL_BIT]};
    assign sc2 = '{ctrl_q[CTRL_MEDIUM_BIT], ctrl_q[CTRL_DIRECT_BIT]};

    // mode, oscillator and exception
    always_comb
    begin
        mode_d = mode_q;
        osc_d = osc_q;
        exc_d = 1'b0;
        if (resetSrc)
        begin
            if (lowPower)
            begin
                osc_d = 1'b1;
            end
            mode_d = MODE_ACTIVE;
        end
        else if (!pinPrev_q && pinSync_q)
        begin
            exc_d = 1'b1;
            osc_d = 1'b1;
        end
        else
        begin
            case (mode_q)
                MODE_ACTIVE:
                begin
                    if (sleepRequest)
                    begin
                        if (!sc1.standbySelect)
                            mode_d = sc1.lowSpeedOn ? MODE_SUBSLEEP
                                : MODE_SLEEP;
                        else if (sc1.timerClockSelectHi)
                            mode_d = MODE_WATCH;
                        else
                            mode_d = MODE_STANDBY;
                        osc_d = !(mode_d != MODE_SLEEP);
                    end
                end
                MODE_SLEEP, MODE_STANDBY, MODE_WATCH, MODE_SUBSLEEP:
                begin
                    if (wakeOk)
                    begin
                        mode_d = (mode_q == MODE_SUBSLEEP)
                            ? MODE_SUBACTIVE : MODE_ACTIVE;
                        osc_d = (mode_d == MODE_ACTIVE);
                    end
                end
                MODE_SUBACTIVE:
                begin
                    if (sleepRequest && wakeOk)
                    begin
                        if (sc1.standbySelect && !sc1.timerClockSelectHi)
                            mode_d = MODE_STANDBY;
                        else if (sc1.standbySelect)
                            mode_d = sc2.directTransferOn
                                ? (sc2.mediumSpeedOn ? MODE_MEDIUM
                                : MODE_ACTIVE) : MODE_WATCH;
                        else if (sc1.lowSpeedOn)
                            mode_d = MODE_SUBSLEEP;
                        else
                            mode_d = MODE_SLEEP;
                        osc_d = (mode_d == MODE_ACTIVE)
                            || (mode_d == MODE_MEDIUM)
                            || (mode_d == MODE_SLEEP);
                    end
                end
                MODE_MEDIUM:
                begin
                    osc_d = 1'b1;
                end
                default:
                begin
                    mode_d = MODE_ACTIVE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_q <= MODE_ACTIVE;
            osc_q <= 1'b1;
            exc_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            osc_q <= osc_d;
            exc_q <= exc_d;
        end
    end

    assign oscEnable = osc_q;
    assign cpuReset = pinLow;
    assign resetException = exc_q;
    assign mode = mode_q;
    assign regsRetained = 1'b1;
    assign memoryRetained = (mode_q != MODE_STANDBY);

    // register bus
    always_comb
    begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        ctrl_d = ctrl_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (awvalid && awready)
        begin
            awHeld_d = 1'b1;
            awAddr_d = awaddr;
        end
        if (wvalid && wready)
        begin
            wHeld_d = 1'b1;
            wData_d = wdata;
            wStrb_d = wstrb;
        end
        if (bvalid_q && bready)
            bvalid_d = 1'b0;
        if (awHeld_q && wHeld_q && !bvalid_q)
        begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            if (awAddr_q[31:2] == ADDR_CONTROL[31:2])
            begin
                if (wStrb_q[0])
                    ctrl_d = wData_q[4:0];
            end
            else if (awAddr_q[31:2] != ADDR_STATUS[31:2])
                bresp_d = RESP_SLVERR;
        end
        if (rvalid_q && rready)
            rvalid_d = 1'b0;
        if (arvalid && arready)
        begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = 32'h0000_0000;
            if (araddr[31:2] == ADDR_CONTROL[31:2])
                rdata_d[4:0] = ctrl_q;
            else if (araddr[31:2] == ADDR_STATUS[31:2])
            begin
                rdata_d[STAT_MODE_LSB +: 3] = mode_q;
                rdata_d[STAT_OSC_BIT] = osc_q && oscStable;
                rdata_d[STAT_CPURST_BIT] = pinLow;
                rdata_d[STAT_EXC_BIT] = exc_q;
            end
            else
                rresp_d = RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 32'h0000_0000;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            ctrl_q <= CONTROL_RESET;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end
        else
        begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            ctrl_q <= ctrl_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign awready = !awHeld_q && !bvalid_q;
    assign wready = !wHeld_q && !bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
endmodule : low_power_mode_exit_reset
`default_nettype wire

// File: dv/lpm_exit_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_exit_asserts
(
    // watched ports
    input wire logic clk,
    input wire logic reset_n,
    input wire logic externalResetPin_n,
    input wire logic interruptMask,
    input wire logic interruptEnabled,
    input wire logic cpuReset,
    input wire logic oscEnable,
    input wire logic resetException,
    input wire logic memoryRetained,
    input wire logic [2:0] mode,
    input wire logic [31:0] rdata,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic rvalid,
    input wire logic rready
);
    import lpm_exit_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_osc_restart: assert property (
        cpuReset |=> oscEnable)
        else $error("oscillator not restarted");
    a_cpu_held: assert property (
        (!externalResetPin_n) [*3] |-> cpuReset)
        else $error("processor not held");
    a_mode_reset: assert property (
        cpuReset |=> mode == MODE_ACTIVE)
        else $error("mode not active in reset");
    a_exc_start: assert property (
        (!externalResetPin_n) [*3] ##1 externalResetPin_n [*3]
        |=> resetException)
        else $error("no exception start");
    a_exc_pulse: assert property (
        resetException |=> !resetException)
        else $error("exception pulse too long");
    a_exc_cause: assert property (
        resetException |-> $past(cpuReset, 2) && !$past(cpuReset))
        else $error("exception without release");
    a_mem_retain: assert property (
        memoryRetained == (mode != MODE_STANDBY))
        else $error("memory retention wrong");
    a_wake_blocked: assert property (
        mode inside {MODE_SUBSLEEP, MODE_SUBACTIVE} && !cpuReset
        && (interruptMask || !interruptEnabled) |=> mode == $past(mode))
        else $error("woke while blocked");
    a_write_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("write answer dropped");
    a_read_hold: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
endmodule : lpm_exit_asserts
bind low_power_mode_exit_reset lpm_exit_asserts u_lpm_exit_asserts (.*);
`default_nettype wire

// File: dv/reset_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module reset_pin_model
(
    // request
    input wire logic clk,
    input wire logic start,
    input wire logic [7:0] releaseCycles,
    // device side
    input wire logic oscStable,
    output var logic pinN = 1'b1,
    output var logic busy = 1'b0
);
    logic [7:0] left = 8'h00;
    always @(posedge clk)
    begin
        if (start)
        begin
            pinN <= 1'b0;
            busy <= 1'b1;
            left <= releaseCycles;
        end
        else if (busy && oscStable)
        begin
            pinN <= left == 8'h00;
            busy <= left != 8'h00;
            left <= left - 8'h01;
        end
    end
endmodule : reset_pin_model
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lpm_exit_pkg::*;
    localparam logic [33:0] WR_OK = {RESP_OKAY, 32'h0};
    logic clk = 1'b0, reset_n = 1'b0, internalResetSrc = 1'b0, start = 1'b0;
    logic sleepRequest = 1'b0, interruptRequest = 1'b0, oscStable = 1'b0;
    logic interruptEnabled = 1'b1, interruptMask = 1'b0, busy, bvalid, rvalid;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, awready, wready;
    logic arvalid = 1'b0, rready = 1'b0, arready, oscEnable, cpuReset;
    logic externalResetPin_n, resetException, memoryRetained, regsRetained;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'hF, oscCnt = 4'h0;
    logic [7:0] rel = 8'h00;
    logic [1:0] bresp, rresp;
    logic [33:0] expq[$];
    mode_e mode;
    integer seed = 57938, miscompares = 0, comparisons = 0;
    logic [4:0] ctl[10] = '{5'h00, 5'h02, 5'h01, 5'h05, 5'h01, 5'h1D, 5'h15,
        5'h05, 5'h02, 5'h00};
    mode_e tgt[10] = '{MODE_SLEEP, MODE_SUBSLEEP, MODE_STANDBY, MODE_WATCH,
        MODE_STANDBY, MODE_MEDIUM, MODE_ACTIVE, MODE_WATCH, MODE_SUBSLEEP,
        MODE_SLEEP};
    always #25 clk = ~clk;
    low_power_mode_exit_reset u_low_power_mode_exit_reset (.*);
    reset_pin_model u_reset_pin_model (.clk(clk), .start(start),
        .releaseCycles(rel), .oscStable(oscStable),
        .pinN(externalResetPin_n), .busy(busy));
    // oscillator settles some cycles after enable
    always @(posedge clk)
        oscCnt <= (oscEnable !== 1'b1) ? 4'h0
            : oscCnt + {3'h0, oscCnt != 4'hF};
    always @(posedge clk)
        oscStable <= oscCnt > 4'h5;
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h",
                $time, seen, exp);
        end
    endtask : chk
    task automatic take(input logic [33:0] seen);
        chk(seen, expq.size() != 0 ? expq.pop_front() : 'x);
    endtask : take
    always @(posedge clk)
        if (reset_n)
        begin
            if (bvalid && bready) take({bresp, 32'h0});
            if (rvalid && rready) take({rresp, rdata});
            if (resetException) take({31'h0, mode});
        end
    task automatic bus(input logic wr, input logic [31:0] a, v,
        input logic [33:0] e);
        expq.push_back(e);
        @(posedge clk) {awvalid, wvalid, arvalid} <= {wr, wr, !wr};
        {awaddr, araddr, wdata} <= {a, a, v};
        #1;
        while (awvalid || wvalid || arvalid)
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            #1;
        end
        repeat (2) @(posedge clk);
        {bready, rready} <= {wr, !wr};
        do @(posedge clk); while (!(bvalid || rvalid));
        {bready, rready} <= 2'b00;
    endtask : bus
    task automatic go(input mode_e m);
        @(posedge clk) sleepRequest <= 1'b1;
        @(posedge clk) sleepRequest <= 1'b0;
        interruptRequest <= 1'b0;
        @(posedge clk) #1 chk({31'h0, mode}, {31'h0, m});
        chk({32'h0, memoryRetained, regsRetained},
            {32'h0, m != MODE_STANDBY, 1'b1});
    endtask : go
    task automatic int_reset;
        @(posedge clk) internalResetSrc <= 1'b1;
        @(posedge clk) internalResetSrc <= 1'b0;
        @(posedge clk) #1 chk({33'h0, oscEnable}, 34'h1);
        chk({31'h0, mode}, {31'h0, MODE_ACTIVE});
    endtask : int_reset
    task automatic pin_reset;
        expq.push_back({31'h0, MODE_ACTIVE});
        @(posedge clk) start <= 1'b1;
        rel <= 8'h04 + (8'($random(seed)) & 8'h0F);
        @(posedge clk) start <= 1'b0;
        do @(posedge clk); while (busy);
        repeat (6) @(posedge clk);
    endtask : pin_reset
    task automatic close_out;
        if (expq.size() != 0) miscompares++;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        // pin seen high after reset starts the exception handling
        expq.push_back({31'h0, MODE_ACTIVE});
        d = {27'h0, 5'($random(seed))};
        bus(1'b0, ADDR_CONTROL, 32'h0, {RESP_OKAY, 27'h0, CONTROL_RESET});
        bus(1'b1, ADDR_CONTROL, d, WR_OK);
        bus(1'b1, 32'h0000_0008, 32'hFFFF_FFFF, {RESP_SLVERR, 32'h0});
        bus(1'b0, ADDR_CONTROL, 32'h0, {RESP_OKAY, d});
        bus(1'b0, ADDR_STATUS, 32'h0, {RESP_OKAY, 32'h1 << STAT_OSC_BIT});
        for (int i = 0; i < 10; i++)
        begin
            if (i >= 4)
            begin
                bus(1'b1, ADDR_CONTROL, 32'h0000_0002, WR_OK);
                go(MODE_SUBSLEEP);
                // even: interrupt disabled, odd: interrupt masked
                @(posedge clk) {interruptMask, interruptEnabled} <= {2{i[0]}};
                interruptRequest <= 1'b1;
                repeat (3) @(posedge clk);
                #1 chk({31'h0, mode}, {31'h0, MODE_SUBSLEEP});
                @(posedge clk) {interruptMask, interruptEnabled} <= 2'b01;
                repeat (2) @(posedge clk);
                #1 chk({31'h0, mode}, {31'h0, MODE_SUBACTIVE});
                @(posedge clk) interruptMask <= 1'b1;
                go(MODE_SUBACTIVE);
                @(posedge clk) {interruptMask, interruptRequest} <= 2'b01;
            end
            bus(1'b1, ADDR_CONTROL, {27'h0, ctl[i]}, WR_OK);
            go(tgt[i]);
            if (i > 0 && i < 4) int_reset;
            pin_reset;
        end
        close_out;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        close_out;
    end
endmodule : tb_top
`default_nettype wire
